// ===== hdl/tpcfg_pkg.sv
// Constants for the test pattern configuration block
package tpcfg_pkg;
	// ==========================================
	// Register offsets and reset values
	localparam logic [7:0] REG_CTRL      = 8'h64;
	localparam logic [7:0] REG_CONF      = 8'h65;
	localparam logic [7:0] REG_IND_ADDR  = 8'h66;
	localparam logic [7:0] REG_IND_DATA  = 8'h67;
	localparam logic [7:0] CTRL_RESET    = 8'h10;
	localparam logic [7:0] CONF_RESET    = 8'h00;
	localparam logic [7:0] IND_RESET     = 8'h00;
	localparam logic [7:0] CONF_WR_MASK  = 8'h7F;
	// ==========================================
	// Field positions
	localparam int CTRL_EN     = 0;
	localparam int CTRL_VREV   = 1;
	localparam int CTRL_BARS   = 2;
	localparam int CTRL_SEL_LO = 4;
	localparam int CONF_SCROLL = 0;
	localparam int CONF_INV    = 1;
	localparam int CONF_TSEL   = 2;
	localparam int CONF_EXTCLK = 3;
	localparam int CONF_D18    = 4;
	localparam int CONF_CUSTOM = 5;
	localparam int CONF_SCALE  = 6;
	// ==========================================
	// Hidden register indices
	localparam int HID_DEPTH  = 32;
	localparam int HID_CR     = 0;
	localparam int HID_CG     = 1;
	localparam int HID_CB     = 2;
	localparam int HID_FT     = 3;
	localparam int HID_HTOT_L = 4;
	localparam int HID_HTOT_H = 5;
	localparam int HID_VTOT_L = 6;
	localparam int HID_VTOT_H = 7;
	localparam int HID_HACT_L = 8;
	localparam int HID_HACT_H = 9;
	localparam int HID_VACT_L = 10;
	localparam int HID_VACT_H = 11;
	localparam int HID_HSW    = 12;
	localparam int HID_VSW    = 13;
	localparam int HID_HBP    = 14;
	localparam int HID_VBP    = 15;
	localparam int HID_SYNC   = 16;
	// ==========================================
	// Timing and data path
	localparam int CLK_PERIOD_NS   = 20;
	localparam int INT_CLK_DIV     = 2;
	localparam logic [3:0] DIV_LAST = 4'(INT_CLK_DIV - 1);
	localparam int FIFO_DEPTH      = 8;
	localparam int PIX_W           = 27;
	localparam logic [23:0] D18_MASK = 24'hFC_FCFC;
	localparam logic [23:0] ALL_ONES = 24'hFF_FFFF;
endpackage : tpcfg_pkg

// ===== hdl/tpcfg_fifo.sv
// Small synchronous FIFO for the pixel stream
`timescale 1ns/1ps
`default_nettype none
module tpcfg_fifo #(
	parameter int W     = 27,
	parameter int DEPTH = 8
) (
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	input  wire logic         ce_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [0:DEPTH-1];
	logic [AW:0]  wr_q;
	logic [AW:0]  rd_q;
	wire          full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire          empty = (wr_q == rd_q);
	wire          push  = in_valid_i && !full;
	wire          pop   = out_ready_i && !empty;

	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = mem_q[rd_q[AW-1:0]];

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (ce_i) begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end

	// Storage has no reset; pointers guard it
	always_ff @(posedge clk_i) begin
		if (ce_i && push) begin
			mem_q[wr_q[AW-1:0]] <= in_data_i;
		end
	end
endmodule : tpcfg_fifo
`default_nettype wire

// ===== hdl/tpcfg_top.sv
// Test pattern generator configuration and pixel source
`timescale 1ns/1ps
`default_nettype none
module tpcfg_top (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	input  wire logic        ce_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic [7:0]       reg_rdata_o,
	input  wire logic        ext_pclk_i,
	input  wire logic        ext_de_i,
	input  wire logic        ext_hs_i,
	input  wire logic        ext_vs_i,
	input  wire logic        pix_ready_i,
	output logic             pix_valid_o,
	output logic [23:0]      pix_rgb_o,
	output logic             pix_de_o,
	output logic             pix_hs_o,
	output logic             pix_vs_o,
	output logic             gen_active_o
);
	// ==========================================
	// Register file
	logic [7:0] ctrl_q;
	logic [7:0] conf_q;
	logic [7:0] ia_q;
	logic [7:0] rdata_q;
	logic [7:0] hid_q [0:tpcfg_pkg::HID_DEPTH-1];

	wire        wr_ctrl = reg_wr_i && (reg_addr_i == tpcfg_pkg::REG_CTRL);
	wire        wr_conf = reg_wr_i && (reg_addr_i == tpcfg_pkg::REG_CONF);
	wire        wr_ia   = reg_wr_i && (reg_addr_i == tpcfg_pkg::REG_IND_ADDR);
	wire        wr_id   = reg_wr_i && (reg_addr_i == tpcfg_pkg::REG_IND_DATA);
	wire        ia_hit  = (ia_q < 8'(tpcfg_pkg::HID_DEPTH));
	wire [7:0]  hid_rd  = ia_hit ? hid_q[ia_q[4:0]] : 8'h00;
	wire [7:0]  rd_mux  = (reg_addr_i == tpcfg_pkg::REG_CTRL)     ? ctrl_q :
	                      (reg_addr_i == tpcfg_pkg::REG_CONF)     ? conf_q :
	                      (reg_addr_i == tpcfg_pkg::REG_IND_ADDR) ? ia_q   :
	                      (reg_addr_i == tpcfg_pkg::REG_IND_DATA) ? hid_rd : 8'h00;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			ctrl_q  <= tpcfg_pkg::CTRL_RESET;
			conf_q  <= tpcfg_pkg::CONF_RESET;
			ia_q    <= tpcfg_pkg::IND_RESET;
			rdata_q <= 8'h00;
		end else if (ce_i) begin
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata_i;
			end
			if (wr_conf) begin
				conf_q <= reg_wdata_i & tpcfg_pkg::CONF_WR_MASK;
			end
			if (wr_ia) begin
				ia_q <= reg_wdata_i;
			end
			if (reg_rd_i) begin
				rdata_q <= rd_mux;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < tpcfg_pkg::HID_DEPTH; i++) begin
				hid_q[i] <= tpcfg_pkg::IND_RESET;
			end
		end else if (ce_i && wr_id && ia_hit) begin
			hid_q[ia_q[4:0]] <= reg_wdata_i;
		end
	end

	wire       en     = ctrl_q[tpcfg_pkg::CTRL_EN];
	wire       scroll = conf_q[tpcfg_pkg::CONF_SCROLL];
	wire       inv    = conf_q[tpcfg_pkg::CONF_INV];
	wire       tsel   = conf_q[tpcfg_pkg::CONF_TSEL];
	wire       extclk = conf_q[tpcfg_pkg::CONF_EXTCLK];
	wire       d18    = conf_q[tpcfg_pkg::CONF_D18];
	wire       custom = conf_q[tpcfg_pkg::CONF_CUSTOM];
	wire       scale  = conf_q[tpcfg_pkg::CONF_SCALE];

	// ==========================================
	// Pin synchronisers, order pclk de hs vs
	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic       pclk_prev_q;
	logic [3:0] div_q;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			meta_q      <= 4'h0;
			sync_q      <= 4'h0;
			pclk_prev_q <= 1'b0;
			div_q       <= 4'h0;
		end else if (ce_i) begin
			meta_q      <= {ext_vs_i, ext_hs_i, ext_de_i, ext_pclk_i};
			sync_q      <= meta_q;
			pclk_prev_q <= sync_q[0];
			div_q       <= (div_q == tpcfg_pkg::DIV_LAST) ? 4'h0 : div_q + 4'h1;
		end
	end

	// External clock is sampled, so it must run well below half of ref_clk
	wire ext_clk_rise = sync_q[0] && !pclk_prev_q;
	wire int_tick     = (div_q == tpcfg_pkg::DIV_LAST);
	wire pix_tick     = (tsel && !extclk) ? int_tick : ext_clk_rise;
	wire fifo_in_rdy;
	wire step         = en && pix_tick && fifo_in_rdy;

	// ==========================================
	// Internal timing
	wire [11:0] htot   = {hid_q[tpcfg_pkg::HID_HTOT_H][3:0], hid_q[tpcfg_pkg::HID_HTOT_L]};
	wire [11:0] vtot   = {hid_q[tpcfg_pkg::HID_VTOT_H][3:0], hid_q[tpcfg_pkg::HID_VTOT_L]};
	wire [11:0] hact   = {hid_q[tpcfg_pkg::HID_HACT_H][3:0], hid_q[tpcfg_pkg::HID_HACT_L]};
	wire [11:0] vact   = {hid_q[tpcfg_pkg::HID_VACT_H][3:0], hid_q[tpcfg_pkg::HID_VACT_L]};
	wire [11:0] hsw    = {4'h0, hid_q[tpcfg_pkg::HID_HSW]};
	wire [11:0] vsw    = {4'h0, hid_q[tpcfg_pkg::HID_VSW]};
	wire [11:0] hstart = hsw + {4'h0, hid_q[tpcfg_pkg::HID_HBP]};
	wire [11:0] vstart = vsw + {4'h0, hid_q[tpcfg_pkg::HID_VBP]};
	wire [7:0]  syncfg = hid_q[tpcfg_pkg::HID_SYNC];

	logic [11:0] hcnt_q;
	logic [11:0] vcnt_q;
	wire         h_wrap = (hcnt_q + 12'h001) >= htot;
	wire         v_wrap = (vcnt_q + 12'h001) >= vtot;
	wire         int_de = (hcnt_q >= hstart) && (hcnt_q < hstart + hact) &&
	                      (vcnt_q >= vstart) && (vcnt_q < vstart + vact);
	wire         int_hs = (hcnt_q < hsw) ^ syncfg[0];
	wire         int_vs = (vcnt_q < vsw) ^ syncfg[1];

	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !en) begin
			hcnt_q <= 12'h000;
			vcnt_q <= 12'h000;
		end else if (ce_i && step && tsel) begin
			hcnt_q <= h_wrap ? 12'h000 : hcnt_q + 12'h001;
			if (h_wrap) begin
				vcnt_q <= v_wrap ? 12'h000 : vcnt_q + 12'h001;
			end
		end
	end

	// ==========================================
	// External timing
	logic [11:0] ext_x_q;
	logic [11:0] ext_y_q;
	logic        ext_de_q;
	logic        ext_vs_q;
	wire         ext_vs_rise = sync_q[3] && !ext_vs_q;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i || !en) begin
			ext_x_q  <= 12'h000;
			ext_y_q  <= 12'h000;
			ext_de_q <= 1'b0;
			ext_vs_q <= 1'b0;
		end else if (ce_i && step && !tsel) begin
			ext_de_q <= sync_q[1];
			ext_vs_q <= sync_q[3];
			ext_x_q  <= sync_q[1] ? ext_x_q + 12'h001 : 12'h000;
			if (ext_vs_rise) begin
				ext_y_q <= 12'h000;
			end else if (ext_de_q && !sync_q[1]) begin
				ext_y_q <= ext_y_q + 12'h001;
			end
		end
	end

	wire        cur_de = tsel ? int_de : sync_q[1];
	wire        cur_hs = tsel ? int_hs : sync_q[2];
	wire        cur_vs = tsel ? int_vs : sync_q[3];
	wire [11:0] x      = tsel ? hcnt_q - hstart : ext_x_q;
	wire [11:0] y      = tsel ? vcnt_q - vstart : ext_y_q;
	wire        frame_end = tsel ? (step && h_wrap && v_wrap) : (step && ext_vs_rise);

	// ==========================================
	// Automatic scrolling
	logic [7:0] frame_cnt_q;
	logic [3:0] scroll_idx_q;
	wire  [7:0] ft        = hid_q[tpcfg_pkg::HID_FT];
	wire        ft_done   = (frame_cnt_q + 8'h01) >= ft;
	wire  [3:0] fixed_sel = ctrl_q[tpcfg_pkg::CTRL_SEL_LO +: 4];
	wire  [3:0] pat_sel   = scroll ? scroll_idx_q : fixed_sel;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			frame_cnt_q  <= 8'h00;
			scroll_idx_q <= 4'h0;
		end else if (ce_i) begin
			if (!scroll) begin
				frame_cnt_q  <= 8'h00;
				scroll_idx_q <= fixed_sel;
			end else if (frame_end) begin
				frame_cnt_q  <= ft_done ? 8'h00 : frame_cnt_q + 8'h01;
				if (ft_done) begin
					scroll_idx_q <= scroll_idx_q + 4'h1;
				end
			end
		end
	end

	// ==========================================
	// Pattern colour
	wire [23:0] cust_col = {hid_q[tpcfg_pkg::HID_CR], hid_q[tpcfg_pkg::HID_CG], hid_q[tpcfg_pkg::HID_CB]};
	wire        chk      = scale ? (x[3] ^ y[3]) : (x[0] ^ y[0]);
	wire [1:0]  band     = scale ? y[4:3] : y[1:0];
	wire [7:0]  lvl_h    = d18 ? {x[5:0], 2'b00} : x[7:0];
	wire [7:0]  lvl_v    = d18 ? {y[5:0], 2'b00} : y[7:0];
	wire [2:0]  bar      = ~x[9:7];

	function automatic logic [23:0] pat_color(
		input logic [3:0]  sel,
		input logic        c,
		input logic [1:0]  b,
		input logic        rev,
		input logic [7:0]  lh,
		input logic [7:0]  lv,
		input logic [23:0] cc,
		input logic        use_cc
	);
		logic [1:0] bi;
		bi = rev ? ~b : b;
		case (sel)
			4'h0: pat_color = c ? (use_cc ? cc : tpcfg_pkg::ALL_ONES) : 24'h00_0000;
			4'h1: pat_color = 24'hFF_FFFF;
			4'h2: pat_color = 24'h00_0000;
			4'h3: pat_color = 24'hFF_0000;
			4'h4: pat_color = 24'h00_FF00;
			4'h5: pat_color = 24'h00_00FF;
			4'h6: pat_color = {lh, lh, lh};
			4'h7: pat_color = {lh, 8'h00, 8'h00};
			4'h8: pat_color = {8'h00, lh, 8'h00};
			4'h9: pat_color = {lv, lv, lv};
			4'hA: pat_color = {lv, 8'h00, 8'h00};
			4'hB: pat_color = {8'h00, lv, 8'h00};
			4'hC: pat_color = {8'h00, 8'h00, lv};
			4'hE: pat_color = cc;
			4'hF: begin
				case (bi)
					2'd0:    pat_color = 24'hFF_FF00;
					2'd1:    pat_color = 24'h00_FFFF;
					2'd2:    pat_color = 24'h00_00FF;
					default: pat_color = 24'hFF_0000;
				endcase
			end
			default: pat_color = 24'h00_0000;
		endcase
	endfunction : pat_color

	wire [23:0] base_col = ctrl_q[tpcfg_pkg::CTRL_BARS] ?
	                       {{8{bar[2]}}, {8{bar[1]}}, {8{bar[0]}}} :
	                       pat_color(pat_sel, chk, band, ctrl_q[tpcfg_pkg::CTRL_VREV],
	                                 lvl_h, lvl_v, cust_col, custom);
	wire [23:0] inv_col  = inv ? (base_col ^ tpcfg_pkg::ALL_ONES) : base_col;
	wire [23:0] dep_col  = d18 ? (inv_col & tpcfg_pkg::D18_MASK) : inv_col;
	wire [23:0] out_col  = cur_de ? dep_col : 24'h00_0000;

	// ==========================================
	// Pixel FIFO and output register
	wire                          fifo_out_vld;
	wire [tpcfg_pkg::PIX_W-1:0]   fifo_out_dat;
	logic                         pix_valid_q;
	logic [tpcfg_pkg::PIX_W-1:0]  pix_q;
	wire                          out_load = !pix_valid_q || pix_ready_i;

	// Full FIFO stalls internal timing; externally timed pixels are then lost
	tpcfg_fifo #(
		.W     (tpcfg_pkg::PIX_W),
		.DEPTH (tpcfg_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i       (ref_clk_i),
		.reset_i     (reset_i),
		.ce_i        (ce_i),
		.in_valid_i  (step),
		.in_ready_o  (fifo_in_rdy),
		.in_data_i   ({cur_de, cur_hs, cur_vs, out_col}),
		.out_valid_o (fifo_out_vld),
		.out_ready_i (out_load),
		.out_data_o  (fifo_out_dat)
	);

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			pix_valid_q <= 1'b0;
			pix_q       <= '0;
		end else if (ce_i && out_load) begin
			pix_valid_q <= fifo_out_vld;
			pix_q       <= fifo_out_dat;
		end
	end

	assign reg_rdata_o  = rdata_q;
	assign pix_valid_o  = pix_valid_q;
	assign pix_de_o     = pix_q[26];
	assign pix_hs_o     = pix_q[25];
	assign pix_vs_o     = pix_q[24];
	assign pix_rgb_o    = pix_q[23:0];
	assign gen_active_o = ctrl_q[tpcfg_pkg::CTRL_EN];

	// ==========================================
	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i || !ce_i);

	a_conf_top_zero: assert property (conf_q[7] == 1'b0)
		else $error("Reserved configuration bit set");
	a_ia_write_load: assert property (wr_ia |=> ia_q == $past(reg_wdata_i))
		else $error("Indirect address not loaded");
	a_id_read_back: assert property (reg_rd_i && reg_addr_i == tpcfg_pkg::REG_IND_DATA
		|=> reg_rdata_o == $past(hid_rd))
		else $error("Indirect read returned wrong value");
	a_id_write_store: assert property (wr_id && ia_hit |=> hid_rd == $past(reg_wdata_i))
		else $error("Indirect write not stored");
	a_int_clk_pick: assert property (tsel && !extclk && en |-> step == (int_tick && fifo_in_rdy))
		else $error("Internal divided clock not used");
	a_ext_timing_tick: assert property (!tsel && en |-> step == (ext_clk_rise && fifo_in_rdy))
		else $error("External timing ignored pixel clock");
	a_d18_low_bits: assert property (d18 |-> out_col[1:0] == 2'b00 && out_col[9:8] == 2'b00)
		else $error("18-bit colour uses low bits");
	a_fixed_sel_hold: assert property (!scroll |=> pat_sel == $past(fixed_sel) || $changed(ctrl_q))
		else $error("Fixed pattern not held");
	a_scroll_advance: assert property (scroll && frame_end && ft_done
		|=> scroll_idx_q == $past(scroll_idx_q) + 4'h1)
		else $error("Scroll did not advance");
	a_disabled_idle: assert property (!en |-> !step ##1 hcnt_q == 12'h000)
		else $error("Generator ran while disabled");
	a_custom_colour: assert property (pat_sel == 4'h0 && !ctrl_q[tpcfg_pkg::CTRL_BARS] && custom && chk
		|-> base_col == cust_col)
		else $error("Custom checker colour not used");
	a_ext_sync_follow: assert property (!tsel |-> cur_hs == sync_q[2] && cur_vs == sync_q[3])
		else $error("External sync not followed");

	// Sink back-pressure must never drop or alter the pixel on show
	a_pix_hold_stall: assert property (pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_rgb_o))
		else $error("Stalled pixel changed");
	a_blank_black: assert property (pix_valid_o && !pix_de_o |-> pix_rgb_o == 24'h00_0000)
		else $error("Blanking pixel not black");

	c_scroll_step: cover property (scroll && frame_end && ft_done);
	c_fifo_full: cover property (en && pix_tick && !fifo_in_rdy);
	c_int_frame: cover property (tsel && frame_end);
	c_ext_frame: cover property (!tsel && frame_end);
	c_id_write: cover property (wr_id ##1 reg_rd_i && reg_addr_i == tpcfg_pkg::REG_IND_DATA);
endmodule : tpcfg_top
`default_nettype wire

// ===== dv/tpcfg_top_tb_top.sv
// Self-checking bench for the test pattern configuration block
`timescale 1ns/1ps
`default_nettype none
module tpcfg_top_tb_top;
	// ==========================================
	// Signals and tables
	localparam logic [7:0] CTL = tpcfg_pkg::REG_CTRL;
	localparam logic [7:0] CNF = tpcfg_pkg::REG_CONF;
	localparam logic [7:0] IA  = tpcfg_pkg::REG_IND_ADDR;
	localparam logic [7:0] ID  = tpcfg_pkg::REG_IND_DATA;
	logic        clk, rst, ce, wr, rd, de, ready, run, pv, pde, phs, pvs, act, hsync, vsync;
	logic        pclk = 1'b0;
	logic [7:0]  addr, wdata, rdata;
	logic [23:0] rgb, vs;
	int          err_count, cmp_count, nval;
	int          pc = 0;
	logic [23:0] q[$];
	bit          f[$];
	// Small frame: 24x8 total, 16x4 active, frame time 1
	logic [7:0]  tv[17] = '{8'h12, 8'h34, 8'h56, 8'h01, 8'h18, 8'h00, 8'h08, 8'h00, 8'h10,
		8'h00, 8'h04, 8'h00, 8'h02, 8'h01, 8'h02, 8'h01, 8'h00};
	logic [3:0]  ps[7] = '{4'h1, 4'h1, 4'h3, 4'h3, 4'hE, 4'h4, 4'h5};
	logic [7:0]  pf[7] = '{8'h04, 8'h06, 8'h04, 8'h16, 8'h14, 8'h04, 8'h04};
	logic [23:0] pe[7] = '{24'hFF_FFFF, 24'h00_0000, 24'hFF_0000, 24'h00_FCFC, 24'h10_3454,
		24'h00_FF00, 24'h00_00FF};

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// External pixel clock at one eighth of the reference, stopped when run is low
	always @(posedge clk) begin
		pc <= pc + 1;
		if (run && pc[1:0] == 2'd3)
			pclk <= ~pclk;
	end

	tpcfg_top dut (
		.ref_clk_i(clk), .reset_i(rst), .ce_i(ce), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .ext_pclk_i(pclk),
		.ext_de_i(de), .ext_hs_i(hsync), .ext_vs_i(vsync), .pix_ready_i(ready),
		.pix_valid_o(pv), .pix_rgb_o(rgb), .pix_de_o(pde), .pix_hs_o(phs), .pix_vs_o(pvs),
		.gen_active_o(act)
	);

	// ==========================================
	// Access and checking tasks
	task automatic check(input string nm, input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : check

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		check(nm, {16'h0000, rdata}, {16'h0000, exp});
	endtask : rchk

	// Collects pixels taken by the sink; flags mark the first pixel of each line
	task automatic grab(input logic [7:0] c, input logic [7:0] cf, input int n);
		bit gap;
		wreg(CTL, c);
		wreg(CNF, cf);
		repeat (40) @(posedge clk);
		q.delete();
		f.delete();
		nval = 0;
		gap  = 1;
		repeat (n) begin
			@(posedge clk);
			if (pv === 1'b1 && ready === 1'b1) begin
				nval++;
				if (pde === 1'b1) begin
					q.push_back(rgb);
					f.push_back(gap);
					gap = 0;
				end else
					gap = 1;
			end
		end
	endtask : grab

	task automatic all_eq(input logic [23:0] exp, input string nm);
		logic [23:0] v;
		v = exp;
		foreach (q[i]) if (q[i] !== exp) v = q[i];
		check(nm, v, exp);
		check("pixel count", 24'(q.size() > 0), 24'h00_0001);
	endtask : all_eq

	// Squares of one pixel differ from each neighbour; 8-wide squares change at most twice a line
	task automatic chk_board(input logic [23:0] c, input bit scale);
		int bad, ch;
		bit sc, s0;
		bad = 0;
		ch  = 0;
		sc  = 0;
		s0  = 0;
		foreach (q[i]) begin
			if (q[i] !== c && q[i] !== 24'h00_0000) bad++;
			if (q[i] === c) sc = 1;
			if (q[i] === 24'h00_0000) s0 = 1;
			if (i > 0 && !f[i]) begin
				if (q[i] !== q[i-1]) ch++;
				else if (!scale) bad++;
			end else begin
				if (scale && ch > 2) bad++;
				ch = 0;
			end
		end
		check("checker", {bad[21:0], sc, s0}, 24'h00_0003);
	endtask : chk_board

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		stop_test();
	end

	// ==========================================
	// Test sequence
	initial begin
		rst = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
		de = 1'b1; ready = 1'b1; run = 1'b0; hsync = 1'b0; vsync = 1'b0;
		err_count = 0;
		cmp_count = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rchk(CTL, tpcfg_pkg::CTRL_RESET, "ctrl reset");
		rchk(CNF, 8'h00, "conf reset");
		rchk(IA, 8'h00, "index reset");
		rchk(ID, 8'h00, "data reset");
		check("active", {23'h00_0000, act}, 24'h00_0000);
		wreg(CNF, 8'hFF);
		rchk(CNF, 8'h7F, "conf top bit");
		ce <= 1'b0;
		wreg(CNF, 8'h00);
		ce <= 1'b1;
		rchk(CNF, 8'h7F, "conf frozen");
		wreg(8'h68, 8'h55);
		rchk(8'h68, 8'h00, "unmapped");
		for (int i = 0; i < 32; i++) begin
			wreg(IA, 8'(i));
			wreg(ID, 8'(i * 7 + 3));
		end
		for (int i = 31; i >= 0; i--) begin
			wreg(IA, 8'(i));
			rchk(ID, 8'(i * 7 + 3), "hidden");
		end
		wreg(IA, 8'h28);
		wreg(ID, 8'h99);
		rchk(ID, 8'h00, "hidden range");
		for (int i = 0; i < 17; i++) begin
			wreg(IA, 8'(i));
			wreg(ID, tv[i]);
		end
		// Solid colours, inversion and 18-bit masking under internal timing
		for (int i = 0; i < 7; i++) begin
			grab({ps[i], 4'h1}, pf[i], 900);
			all_eq(pe[i], "solid");
		end
		check("active", {23'h00_0000, act}, 24'h00_0001);
		grab(8'h01, 8'h04, 900);
		chk_board(24'hFF_FFFF, 1'b0);
		grab(8'h01, 8'h24, 900);
		chk_board(24'h12_3456, 1'b0);
		grab(8'h01, 8'h44, 900);
		chk_board(24'hFF_FFFF, 1'b1);
		grab(8'h61, 8'h04, 900);
		vs = 24'h00_0000;
		foreach (q[i]) vs = vs | q[i];
		check("ramp fine", 24'(vs[1:0] != 2'b00), 24'h00_0001);
		grab(8'h61, 8'h14, 900);
		vs = 24'h00_0000;
		foreach (q[i]) vs = vs | q[i];
		check("ramp coarse", {22'h00_0000, vs[1:0]}, 24'h00_0000);
		check("ramp used", 24'(vs[7:2] != 6'h00), 24'h00_0001);
		// Fixed white selected, scrolling must move away from it
		grab(8'h11, 8'h05, 2000);
		vs = 24'hFF_FFFF;
		foreach (q[i]) if (q[i] !== 24'hFF_FFFF) vs = q[i];
		check("scroll moved", 24'(vs !== 24'hFF_FFFF), 24'h00_0001);
		// Clock source: external clock stopped must starve internal timing only when selected
		grab(8'h11, 8'h0C, 400);
		check("ext clock idle", 24'(nval), 24'h00_0000);
		run <= 1'b1;
		grab(8'h11, 8'h0C, 900);
		all_eq(24'hFF_FFFF, "ext clock run");
		run <= 1'b0;
		grab(8'h11, 8'h00, 400);
		check("ext timing idle", 24'(nval), 24'h00_0000);
		run <= 1'b1;
		grab(8'h11, 8'h08, 900);
		all_eq(24'hFF_FFFF, "ext timing");
		check("ext syncs low", {22'h00_0000, phs, pvs}, 24'h00_0000);
		hsync <= 1'b1;
		vsync <= 1'b1;
		grab(8'h11, 8'h00, 400);
		check("ext syncs high", {22'h00_0000, phs, pvs}, 24'h00_0003);
		hsync <= 1'b0;
		vsync <= 1'b0;
		de <= 1'b0;
		grab(8'h11, 8'h00, 400);
		check("ext blank", {23'h00_0000, nval > 0 && q.size() == 0}, 24'h00_0001);
		de  <= 1'b1;
		run <= 1'b0;
		// Sink stall holds the pixel
		grab(8'h01, 8'h04, 100);
		ready <= 1'b0;
		repeat (3) @(posedge clk);
		vs = rgb;
		repeat (20) @(posedge clk);
		check("stall data", rgb, vs);
		check("stall valid", {23'h00_0000, pv}, 24'h00_0001);
		ready <= 1'b1;
		grab(8'h10, 8'h04, 400);
		check("disabled", 24'(nval), 24'h00_0000);
		check("inactive", {23'h00_0000, act}, 24'h00_0000);
		stop_test();
	end
endmodule : tpcfg_top_tb_top
`default_nettype wire
